// ---- pll_clock_pattern_config.sv ----
`timescale 1ns/1ps
// What this block does
// - odd address reads back the even register
// - bit one selects high loop bandwidth
// - pll bit zero restarts oscillator calibration
// - lost lock starts calibration without host
// - input bit five inverts reference clock
// - bits four..two enable wide, medium, narrow hysteresis
// - input bit one disables default hysteresis
// - input bit zero disables all hysteresis
// - low pattern register gives pattern bits 7:0
// - high register bits 3:0 give bits 11:8
// - custom pattern sent when sequence three selected
module pll_clock_pattern_config (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_sclk,
    input  wire logic       i_cs_n,
    input  wire logic       i_sdi,
    input  wire logic       i_pll_locked,
    input  wire logic [1:0] i_training_select,
    output logic            o_sdo,
    output logic            o_sdo_oe,
    output logic            o_loop_bandwidth_high,
    output logic            o_oscillator_cal_restart,
    output logic            o_ref_clock_invert,
    output logic            o_hyst_wide_enable,
    output logic            o_hyst_medium_enable,
    output logic            o_hyst_narrow_enable,
    output logic            o_default_hyst_enable,
    output logic            o_custom_pattern_select,
    output logic [11:0]     o_training_word
);
    import pll_cfg_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_HEADER  = 4'b0010,
        ST_PAYLOAD = 4'b0100,
        ST_DONE    = 4'b1000
    } serial_state_type;

    serial_state_type state_reg;
    logic [3:0]       pins_q;
    logic             sclk_q;
    logic             cs_n_q;
    logic             sdi_q;
    logic             locked_q;
    logic             sclk_d_reg;
    logic             sclk_rise;
    logic             sclk_fall;
    logic [4:0]       bit_cnt_reg;
    logic [7:0]       in_shift_reg;
    logic [7:0]       out_shift_reg;
    logic             read_reg;
    logic [6:0]       addr_reg;
    logic             wr_stb_reg;
    logic [6:0]       wr_addr_reg;
    logic [7:0]       wr_data_reg;
    logic [7:0]       pll_ctrl_reg;
    logic [7:0]       clk_in_reg;
    logic [7:0]       pat_low_reg;
    logic [7:0]       pat_high_reg;
    logic [7:0]       header_next;
    logic             manual_cal_req;
    logic [11:0]      pattern;

    // odd address returns its even partner; everything else reads zero
    function automatic logic [7:0] read_value(input logic [6:0] addr,
                                              input logic [7:0] pll,
                                              input logic [7:0] clk_in,
                                              input logic [7:0] pat_lo,
                                              input logic [7:0] pat_hi);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            PLL_CTRL_RB_OFS: v = pll;
            CLK_IN_RB_OFS:   v = clk_in;
            PAT_LOW_RB_OFS:  v = pat_lo;
            PAT_HIGH_RB_OFS: v = pat_hi;
            default:         v = 8'h00;
        endcase
        return v;
    endfunction

    // serial pins come from the host's domain
    pin_sync #(
        .WIDTH   (4),
        .RST_VAL (PIN_SYNC_RST)
    ) pin_sync_inst (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_pins  ({i_pll_locked, i_cs_n, i_sclk, i_sdi}),
        .o_pins  (pins_q)
    );

    assign sdi_q    = pins_q[0];
    assign sclk_q   = pins_q[1];
    assign cs_n_q   = pins_q[2];
    assign locked_q = pins_q[3];

    // serial clock edge detect on the filtered level
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_q;
        end
    end

    assign sclk_rise   = sclk_q & ~sclk_d_reg;
    assign sclk_fall   = ~sclk_q & sclk_d_reg;
    assign header_next = {in_shift_reg[6:0], sdi_q};

    // frame sequencer; deselect always aborts a partial frame
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 5'h00;
        end else if (cs_n_q) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 5'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_HEADER;
                end
                ST_HEADER: begin
                    if (sclk_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        if (bit_cnt_reg == 5'(HEADER_BITS - 1)) begin
                            state_reg <= ST_PAYLOAD;
                        end
                    end
                end
                ST_PAYLOAD: begin
                    if (sclk_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        if (bit_cnt_reg == 5'(FRAME_BITS - 1)) begin
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_DONE; // extra clocks ignored until deselect
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // input shifter and header capture
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            in_shift_reg <= 8'h00;
            read_reg     <= 1'b0;
            addr_reg     <= 7'h00;
        end else if (sclk_rise && !cs_n_q &&
                     (state_reg == ST_HEADER || state_reg == ST_PAYLOAD)) begin
            in_shift_reg <= header_next;
            if (state_reg == ST_HEADER && bit_cnt_reg == 5'(HEADER_BITS - 1)) begin
                read_reg <= header_next[READ_FLAG_BIT];
                addr_reg <= header_next[6:0];
            end
        end
    end

    // write strobe fires once, on the last bit of a full write frame
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_stb_reg  <= 1'b0;
            wr_addr_reg <= 7'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_stb_reg <= 1'b0;
            if (sclk_rise && !cs_n_q && state_reg == ST_PAYLOAD &&
                bit_cnt_reg == 5'(FRAME_BITS - 1) && !read_reg) begin
                wr_stb_reg  <= 1'b1;
                wr_addr_reg <= addr_reg;
                wr_data_reg <= header_next;
            end
        end
    end

    // readback shifter: load after header, drive on falling edges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_shift_reg <= 8'h00;
            o_sdo         <= 1'b0;
            o_sdo_oe      <= 1'b0;
        end else if (cs_n_q) begin
            o_sdo_oe <= 1'b0;
            o_sdo    <= 1'b0;
        end else if (sclk_rise && state_reg == ST_HEADER &&
                     bit_cnt_reg == 5'(HEADER_BITS - 1)) begin
            out_shift_reg <= read_value(header_next[6:0], pll_ctrl_reg, clk_in_reg,
                                        pat_low_reg, pat_high_reg);
        end else if (sclk_fall && state_reg == ST_PAYLOAD && read_reg) begin
            o_sdo         <= out_shift_reg[7];
            o_sdo_oe      <= 1'b1;
            out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        end else if (state_reg == ST_DONE && sclk_fall) begin
            o_sdo_oe <= 1'b0;
        end
    end

    // register bank; all eight bits stored so readback is exact
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pll_ctrl_reg <= PLL_CTRL_RST;
            clk_in_reg   <= CLK_IN_RST;
            pat_low_reg  <= PAT_LOW_RST;
            pat_high_reg <= PAT_HIGH_RST;
        end else if (wr_stb_reg) begin
            case (wr_addr_reg)
                PLL_CTRL_OFS: pll_ctrl_reg <= wr_data_reg;
                CLK_IN_OFS:   clk_in_reg   <= wr_data_reg;
                PAT_LOW_OFS:  pat_low_reg  <= wr_data_reg;
                PAT_HIGH_OFS: pat_high_reg <= wr_data_reg;
                default:      pll_ctrl_reg <= pll_ctrl_reg; // odd and unmapped ignored
            endcase
        end
    end

    // the write itself is the trigger, not the stored level
    assign manual_cal_req = wr_stb_reg && wr_addr_reg == PLL_CTRL_OFS &&
                            wr_data_reg[CAL_RESTART_BIT];

    cal_trigger cal_trigger_inst (
        .i_clk        (i_clk),
        .i_rst_n      (i_rst_n),
        .i_manual_req (manual_cal_req),
        .i_locked     (locked_q),
        .o_cal_start  (o_oscillator_cal_restart)
    );

    // analog controls; all-off masks every individual enable
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_loop_bandwidth_high <= 1'b0;
            o_ref_clock_invert    <= 1'b0;
            o_hyst_wide_enable    <= 1'b0;
            o_hyst_medium_enable  <= 1'b0;
            o_hyst_narrow_enable  <= 1'b0;
            o_default_hyst_enable <= 1'b1;
        end else begin
            o_loop_bandwidth_high <= pll_ctrl_reg[BANDWIDTH_HIGH_BIT];
            o_ref_clock_invert    <= clk_in_reg[REF_INVERT_BIT];
            o_hyst_wide_enable    <= clk_in_reg[HYST_WIDE_BIT] &
                                     ~clk_in_reg[ALL_HYST_OFF_BIT];
            o_hyst_medium_enable  <= clk_in_reg[HYST_MEDIUM_BIT] &
                                     ~clk_in_reg[ALL_HYST_OFF_BIT];
            o_hyst_narrow_enable  <= clk_in_reg[HYST_NARROW_BIT] &
                                     ~clk_in_reg[ALL_HYST_OFF_BIT];
            o_default_hyst_enable <= ~clk_in_reg[DEFAULT_HYST_OFF_BIT] &
                                     ~clk_in_reg[ALL_HYST_OFF_BIT];
        end
    end

    // reserved high nibble never reaches the serializer
    assign pattern = {pat_high_reg[PAT_HIGH_MSB:0], pat_low_reg};

    // training word to the serializer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_custom_pattern_select <= 1'b0;
            o_training_word         <= TRAINING_IDLE;
        end else begin
            o_custom_pattern_select <= (i_training_select == CUSTOM_SEQ_SEL);
            o_training_word <= (i_training_select == CUSTOM_SEQ_SEL) ?
                               pattern : TRAINING_IDLE;
        end
    end

    chk_readback_load:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (sclk_rise && !cs_n_q && state_reg == ST_HEADER &&
         bit_cnt_reg == 5'(HEADER_BITS - 1) && header_next[6:0] == PLL_CTRL_RB_OFS)
        |=> out_shift_reg == $past(pll_ctrl_reg))
    else $error("pll readback did not load last written value");

    chk_bandwidth_follow:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_stb_reg && wr_addr_reg == PLL_CTRL_OFS)
        |=> ##1 o_loop_bandwidth_high == $past(wr_data_reg[BANDWIDTH_HIGH_BIT], 2))
    else $error("bandwidth select did not follow write");

    chk_cal_manual_pulse:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        manual_cal_req |=> o_oscillator_cal_restart)
    else $error("calibration write did not restart calibration");

    chk_cal_one_shot:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_oscillator_cal_restart && !$past(manual_cal_req))
        |-> $past(locked_q, 2) && !$past(locked_q))
    else $error("calibration fired without a write or lock loss");

    chk_invert_follow:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $changed(clk_in_reg) |=> o_ref_clock_invert == $past(clk_in_reg[REF_INVERT_BIT]))
    else $error("reference invert did not follow register");

    chk_hyst_all_off:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        clk_in_reg[ALL_HYST_OFF_BIT] [*2] |-> !o_hyst_wide_enable &&
        !o_hyst_medium_enable && !o_hyst_narrow_enable && !o_default_hyst_enable)
    else $error("hysteresis active while all disabled");

    chk_default_hyst:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $past(clk_in_reg[DEFAULT_HYST_OFF_BIT]) |-> !o_default_hyst_enable)
    else $error("default hysteresis not disabled");

    chk_wide_hyst:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ($past(clk_in_reg[HYST_WIDE_BIT]) && !$past(clk_in_reg[ALL_HYST_OFF_BIT]))
        |-> o_hyst_wide_enable)
    else $error("wide hysteresis not enabled");

    chk_custom_word:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_training_select == CUSTOM_SEQ_SEL)
        |=> o_training_word == {$past(pat_high_reg[PAT_HIGH_MSB:0]), $past(pat_low_reg)})
    else $error("custom training word mismatch");

endmodule

// ---- pll_cfg_pkg.sv ----
package pll_cfg_pkg;

    // register offsets (write side even, readback side odd)
    localparam logic [6:0] PLL_CTRL_OFS      = 7'h08;
    localparam logic [6:0] PLL_CTRL_RB_OFS   = 7'h09;
    localparam logic [6:0] CLK_IN_OFS        = 7'h0a;
    localparam logic [6:0] CLK_IN_RB_OFS     = 7'h0b;
    localparam logic [6:0] PAT_LOW_OFS       = 7'h10;
    localparam logic [6:0] PAT_LOW_RB_OFS    = 7'h11;
    localparam logic [6:0] PAT_HIGH_OFS      = 7'h12;
    localparam logic [6:0] PAT_HIGH_RB_OFS   = 7'h13;

    // reset values
    localparam logic [7:0] PLL_CTRL_RST      = 8'h00;
    localparam logic [7:0] CLK_IN_RST        = 8'h00;
    localparam logic [7:0] PAT_LOW_RST       = 8'h00;
    localparam logic [7:0] PAT_HIGH_RST      = 8'h00;

    // clock pll control fields
    localparam int CAL_RESTART_BIT           = 0;
    localparam int BANDWIDTH_HIGH_BIT        = 1;

    // clock input conditioning fields
    localparam int ALL_HYST_OFF_BIT          = 0;
    localparam int DEFAULT_HYST_OFF_BIT      = 1;
    localparam int HYST_NARROW_BIT           = 2;
    localparam int HYST_MEDIUM_BIT           = 3;
    localparam int HYST_WIDE_BIT             = 4;
    localparam int REF_INVERT_BIT            = 5;

    // training pattern fields
    localparam int PAT_HIGH_MSB              = 3;
    localparam logic [1:0] CUSTOM_SEQ_SEL    = 2'h3;
    localparam logic [11:0] TRAINING_IDLE    = 12'h000;

    // serial frame: read flag, 7-bit address, 8-bit data, msb first
    localparam int FRAME_BITS                = 16;
    localparam int HEADER_BITS               = 8;
    localparam int READ_FLAG_BIT             = 7;

    // pin synchroniser reset levels, order {locked, cs_n, sclk, sdi}
    localparam logic [3:0] PIN_SYNC_RST      = 4'hc;

endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
// three-stage synchroniser; output follows once stages two and three agree
module pin_sync #(
    parameter int              WIDTH   = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_pins
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] mid_reg;
    logic [WIDTH-1:0] late_reg;

    // stage one is read by stage two only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= RST_VAL;
            mid_reg  <= RST_VAL;
            late_reg <= RST_VAL;
        end else begin
            meta_reg <= i_pins;
            mid_reg  <= meta_reg;
            late_reg <= mid_reg;
        end
    end

    // per-bit agreement filter rejects a single-sample glitch
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pins <= RST_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (mid_reg[i] == late_reg[i]) begin
                    o_pins[i] <= late_reg[i];
                end
            end
        end
    end

endmodule

// ---- cal_trigger.sv ----
`timescale 1ns/1ps
// one-cycle calibration start from a host write or a lost lock
module cal_trigger (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_manual_req,
    input  wire logic i_locked,
    output logic      o_cal_start
);

    logic locked_d_reg;
    logic lock_lost;

    // locked reset high so an unlocked pll after reset calibrates at once
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            locked_d_reg <= 1'b1;
        end else begin
            locked_d_reg <= i_locked;
        end
    end

    assign lock_lost = locked_d_reg & ~i_locked;

    // single pulse per event; a stored bit never retriggers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cal_start <= 1'b0;
        end else begin
            o_cal_start <= i_manual_req | lock_lost;
        end
    end

    chk_lock_loss_cal:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(i_locked) |=> o_cal_start)
    else $error("lock loss did not start calibration");

endmodule

// ---- serial_host.sv ----
`timescale 1ns/1ps
// host on the serial control port: mode 0, drives on sclk fall, samples on rise
module serial_host (
    input  wire logic i_clk,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe,
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sdi
);
    import pll_cfg_pkg::*;

    // four times the filter minimum, so a slow host is what the block sees
    localparam int PHASE = 8;

    // serial clock stands still low outside frames
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // reserved positions always leave the host as zero
    function automatic logic [7:0] legal_bits(input logic [6:0] addr);
        case (addr)
            PLL_CTRL_OFS: legal_bits = 8'h03;
            CLK_IN_OFS:   legal_bits = 8'h3f;
            PAT_HIGH_OFS: legal_bits = 8'h0f;
            default:      legal_bits = 8'hff;
        endcase
    endfunction

    // one whole frame, msb first; rdata collects the last eight sampled bits
    task automatic transfer(input logic rd, input logic [6:0] addr,
                            input logic [7:0] wdata, output logic [7:0] rdata,
                            output logic oe_ok);
        logic [15:0] frame;
        frame = {rd, addr, wdata & legal_bits(addr)};
        oe_ok = 1'b1;
        rdata = 8'h00;
        tick(1);
        o_cs_n = 1'b0;
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            o_sdi = frame[i];
            tick(PHASE);
            o_sclk = 1'b1;
            if (i < HEADER_BITS) begin
                rdata = {rdata[6:0], i_sdo};
                oe_ok = oe_ok & i_sdo_oe;
            end
            tick(PHASE);
            o_sclk = 1'b0;
        end
        o_sdi = ~o_sdi; // after the frame the line carries no stale bit
        tick(PHASE);
        o_cs_n = 1'b1;
        tick(PHASE);
    endtask
endmodule

// ---- pll_clock_pattern_config_tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module pll_clock_pattern_config_tb;
    import pll_cfg_pkg::*;

    logic        i_clk, i_rst_n, i_sclk, i_cs_n, i_sdi, i_pll_locked;
    logic [1:0]  i_training_select;
    logic        o_sdo, o_sdo_oe, o_loop_bandwidth_high, o_oscillator_cal_restart;
    logic        o_ref_clock_invert, o_hyst_wide_enable, o_hyst_medium_enable;
    logic        o_hyst_narrow_enable, o_default_hyst_enable, o_custom_pattern_select;
    logic [11:0] o_training_word;
    int          miscompares, check_count, cal_pulses, cycles;

    pll_clock_pattern_config pll_clock_pattern_config_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
        .i_sdi(i_sdi), .i_pll_locked(i_pll_locked), .i_training_select(i_training_select),
        .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_loop_bandwidth_high(o_loop_bandwidth_high),
        .o_oscillator_cal_restart(o_oscillator_cal_restart),
        .o_ref_clock_invert(o_ref_clock_invert), .o_hyst_wide_enable(o_hyst_wide_enable),
        .o_hyst_medium_enable(o_hyst_medium_enable),
        .o_hyst_narrow_enable(o_hyst_narrow_enable),
        .o_default_hyst_enable(o_default_hyst_enable),
        .o_custom_pattern_select(o_custom_pattern_select), .o_training_word(o_training_word));

    serial_host serial_host_inst (
        .i_clk(i_clk), .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe),
        .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi));

    // 250 MHz system clock
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // every calibration pulse is counted, so extra or missing ones show up
    always @(posedge i_clk) begin
        if (o_oscillator_cal_restart === 1'b1) cal_pulses++;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] rd;
        logic       oe;
        serial_host_inst.transfer(1'b0, addr, data, rd, oe);
    endtask

    // readback frame; the payload must be driven through all eight bits
    task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
        logic [7:0] rd;
        logic       oe;
        serial_host_inst.transfer(1'b1, addr, 8'h00, rd, oe);
        `CHK(rd, exp)
        `CHK(oe, 1'b1)
    endtask

    task automatic test_reset();
        `CHK(o_loop_bandwidth_high, 1'b0)
        `CHK(o_default_hyst_enable, 1'b1)
        `CHK(o_training_word, 12'h000)
        rd_chk(PLL_CTRL_RB_OFS, PLL_CTRL_RST);
        rd_chk(CLK_IN_RB_OFS, CLK_IN_RST);
        rd_chk(PAT_LOW_RB_OFS, PAT_LOW_RST);
        rd_chk(PAT_HIGH_RB_OFS, PAT_HIGH_RST);
        $display("test_reset done");
    endtask

    task automatic test_pll();
        int base;
        base = cal_pulses;
        wr(PLL_CTRL_OFS, 8'hfe);
        `CHK(o_loop_bandwidth_high, 1'b1)
        `CHK(cal_pulses, base)
        rd_chk(PLL_CTRL_RB_OFS, 8'h02);
        wr(PLL_CTRL_OFS, 8'h03);
        `CHK(cal_pulses, base + 1)
        rd_chk(PLL_CTRL_OFS, 8'h00);
        wr(PLL_CTRL_OFS, 8'h03);
        tick(40);
        `CHK(cal_pulses, base + 2)
        wr(PLL_CTRL_OFS, 8'h00);
        `CHK(o_loop_bandwidth_high, 1'b0)
        `CHK(cal_pulses, base + 2)
        wr(PLL_CTRL_RB_OFS, 8'hff);
        rd_chk(PLL_CTRL_RB_OFS, 8'h00);
        $display("test_pll done");
    endtask

    task automatic test_lock();
        int base;
        base = cal_pulses;
        i_pll_locked = 1'b0;
        tick(12);
        `CHK(cal_pulses, base + 1)
        i_pll_locked = 1'b1;
        tick(12);
        `CHK(cal_pulses, base + 1)
        $display("test_lock done");
    endtask

    // narrow only alone, wide and medium only with default off, as a host would
    task automatic test_clk_in();
        logic [7:0] vals [7];
        logic [7:0] v;
        vals = '{8'h20, 8'h12, 8'h0a, 8'h04, 8'h13, 8'h01, 8'h00};
        foreach (vals[k]) begin
            v = vals[k];
            wr(CLK_IN_OFS, v);
            `CHK(o_ref_clock_invert, v[REF_INVERT_BIT])
            `CHK(o_hyst_wide_enable, v[HYST_WIDE_BIT] & ~v[ALL_HYST_OFF_BIT])
            `CHK(o_hyst_medium_enable, v[HYST_MEDIUM_BIT] & ~v[ALL_HYST_OFF_BIT])
            `CHK(o_hyst_narrow_enable, v[HYST_NARROW_BIT] & ~v[ALL_HYST_OFF_BIT])
            `CHK(o_default_hyst_enable, ~v[DEFAULT_HYST_OFF_BIT] & ~v[0])
            rd_chk(CLK_IN_RB_OFS, v);
        end
        $display("test_clk_in done");
    endtask

    task automatic test_pattern();
        wr(PAT_LOW_OFS, 8'ha5);
        wr(PAT_HIGH_OFS, 8'hfc);
        for (int s = 0; s < 4; s++) begin
            i_training_select = s[1:0];
            tick(2);
            `CHK(o_custom_pattern_select, (s == 3))
            `CHK(o_training_word, (s == 3) ? 12'hca5 : TRAINING_IDLE)
        end
        wr(PAT_LOW_OFS, 8'h3c);
        `CHK(o_training_word, 12'hc3c)
        rd_chk(PAT_LOW_RB_OFS, 8'h3c);
        rd_chk(PAT_HIGH_RB_OFS, 8'h0c);
        i_training_select = 2'h0;
        tick(2);
        `CHK(o_training_word, TRAINING_IDLE)
        $display("test_pattern done");
    endtask

    // reset for three cycles, then every scenario in turn
    initial begin
        miscompares = 0;
        check_count = 0;
        cal_pulses = 0;
        cycles = 0;
        i_rst_n = 1'b0;
        i_pll_locked = 1'b1;
        i_training_select = 2'h0;
        repeat (3) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        tick(10);
        test_reset();
        test_pll();
        test_lock();
        test_clk_in();
        test_pattern();
        wrap_up();
    end
endmodule
